// ===== csf_top.sv
// Purpose: status and setup-control flags of the calendar block, apb slave
// Assumes: calendar events arrive as one-cycle pulses synchronous to clk
// Notes:   the setup request crosses a two-stage synchroniser before counters stop
//          field positions and offsets come from the register header
//
// Overview of operation
// RULE_01: the wakeup flag sets whenever the wakeup down-counter reaches zero.
// RULE_02: wakeup and both alarm flags clear only when software writes zero to them.
// RULE_03: software clears the wakeup flag at least 1.5 calendar clocks before it re-sets.
// RULE_04: the second alarm flag sets when time and date match the second alarm register.
// RULE_05: the first alarm flag sets when time and date match the first alarm register.
// RULE_06: a set setup request halts the counters, and clearing it resumes counting.
// RULE_07: the setup-active bit shows when calendar registers may be written.
// RULE_08: the shadow synced flag sets each time live values copy into the shadows.
// RULE_09: the synced flag is held clear in setup, with a shift pending, or in bypass.
// RULE_10: software may clear the synced flag itself.
// RULE_11: the programmed indicator reads one whenever the year field is nonzero.
// RULE_12: the shift pending flag sets on a shift register write and clears when applied; here it clears a fixed 4 cycles after the write.
// RULE_13: writes to the shift pending flag are ignored.
// RULE_14: writing one to a clearable flag leaves it unchanged.
// RULE_15: setup-active asserts only after the synchronised request has stopped counters.
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/100ps
`include "csf_regs.svh"
module csf_top
  import csf_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // calendar events
  input  wire logic        wakeup_zero,
  input  wire logic        first_alarm_match,
  input  wire logic        second_alarm_match,
  input  wire logic        shadow_copy,
  input  wire logic        counters_stopped,
  input  wire logic [7:0]  year_field,
  // calendar controls
  output logic             counter_halt_q,
  output logic             shift_start_q,
  output logic             shadow_bypass_select_q
);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire        setup_ph   = psel & ~penable;
  wire        access_ph  = psel & penable;
  wire        sel_status = (paddr == `CSF_STATUS_OFS);
  wire        sel_shift  = (paddr == `CSF_SHIFT_OFS);
  wire        sel_ctrl   = (paddr == `CSF_CTRL_OFS);
  wire        mapped     = sel_status | sel_shift | sel_ctrl;
  wire        wr_ok      = access_ph & pwrite & mapped & pstrb[1];
  wire        wr_status  = wr_ok & sel_status;
  // the shift register is write only; any lane-1 write starts an adjustment
  wire        wr_shift   = wr_ok & sel_shift;
  wire        wr_ctrl    = wr_ok & sel_ctrl & pstrb[0];
  // byte lane 1 holds bits 15:8, lane 0 holds bits 7:0
  wire        wr_lane0   = access_ph & pwrite & sel_status & pstrb[0];
  wire        rd_setup   = setup_ph & ~pwrite;
  wire [2:0]  flag_wdata = pwdata[`CSF_WAKEUP_BIT:`CSF_ALARM1_BIT];

  // ----------------------------------------------------------------
  // flag and state storage
  // ----------------------------------------------------------------
  logic wakeup_expired_flag;
  logic second_alarm_flag;
  logic first_alarm_flag;
  logic shadow_synced_flag;
  logic shift_pending_flag;
  logic setup_req_q;
  logic setup_req_sync;
  logic calendar_programmed_q;
  logic [3:0] shift_cnt_q;
  csf_setup_state_t state_q;
  csf_setup_state_t state_d;

  // ----------------------------------------------------------------
  // sticky event flags
  // ----------------------------------------------------------------
  wire [2:0] ev_set;
  wire [2:0] ev_clr;
  wire [2:0] ev_flag;
  assign ev_set = {wakeup_zero, second_alarm_match, first_alarm_match}; // RULE_01 RULE_04 RULE_05
  // zero clears, one leaves the flag alone
  assign ev_clr = {3{wr_status}} & ~flag_wdata; // RULE_02 RULE_14

  // one cell per event keeps the set-wins rule in a single place
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_ev
      csf_flag u_flag (
        .clk    (clk),
        .rst_n  (rst_n),
        .set_i  (ev_set[gi]),
        .clr_i  (ev_clr[gi]),
        .flag_q (ev_flag[gi])
      );
    end
  endgenerate
  // ev_* bits run in status word order, first alarm lowest
  assign first_alarm_flag    = ev_flag[0];
  assign second_alarm_flag   = ev_flag[1];
  assign wakeup_expired_flag = ev_flag[2];

  // ----------------------------------------------------------------
  // setup mode handshake
  // ----------------------------------------------------------------
  wire setup_mode_active = (state_q == CSF_SETUP); // RULE_07

  // written from lane 0 only, so a flag clear on lane 1 leaves the request alone
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      setup_req_q <= 1'b0;
    else if (wr_lane0)
      setup_req_q <= pwdata[`CSF_INIT_BIT];
  end

  // request must cross into the counter domain before the handshake and the counters react
  csf_sync u_setup_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (setup_req_q),
    .q     (setup_req_sync)
  );

  // leaving setup waits for no answer from the counters; they restart at once
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      CSF_RUN:
        if (setup_req_sync)
          state_d = CSF_STOPPING;
      CSF_STOPPING:
        if (!setup_req_sync)
          state_d = CSF_RUN;
        else if (counters_stopped)
          state_d = CSF_SETUP; // RULE_15
      CSF_SETUP:
        if (!setup_req_sync)
          state_d = CSF_RUN; // RULE_06
      default:
        state_d = CSF_RUN;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      state_q <= CSF_RUN;
    else
      state_q <= state_d;
  end

  // the counters see the request only after it has crossed the synchroniser
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      counter_halt_q <= 1'b0;
    else
      counter_halt_q <= setup_req_sync; // RULE_06
  end

  // ----------------------------------------------------------------
  // shift pending, bypass select, year indicator
  // ----------------------------------------------------------------
  // no apply input: completion is a fixed count until a shift unit reports back
  wire shift_done = shift_pending_flag & (shift_cnt_q == 4'h1);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      shift_start_q <= 1'b0;
    else
      shift_start_q <= wr_shift;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      shift_pending_flag <= 1'b0;
      shift_cnt_q        <= 4'h0;
    end
    else if (wr_shift)
    begin
      shift_pending_flag <= 1'b1; // RULE_12
      shift_cnt_q        <= `CSF_SHIFT_CYCLES;
    end
    else if (shift_done)
    begin
      shift_pending_flag <= 1'b0; // RULE_12
      shift_cnt_q        <= 4'h0;
    end
    else if (shift_pending_flag)
      shift_cnt_q <= shift_cnt_q - 4'h1;
  end

  // bypass is kept across setup mode; software alone owns it
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      shadow_bypass_select_q <= 1'b0;
    else if (wr_ctrl)
      shadow_bypass_select_q <= pwdata[`CSF_BYPASS_BIT];
  end

  // registered so a read never sees the year field mid-change
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      calendar_programmed_q <= 1'b0;
    else
      calendar_programmed_q <= (year_field != 8'h00); // RULE_11
  end

  // ----------------------------------------------------------------
  // shadow synced flag
  // ----------------------------------------------------------------
  // hold-clear conditions beat the copy event, the copy beats software
  wire sync_hold = setup_req_q | setup_req_sync | setup_mode_active | shift_pending_flag
                   | shadow_bypass_select_q; // RULE_09
  wire sync_clr  = wr_lane0 & ~pwdata[`CSF_SYNCED_BIT]; // RULE_10 RULE_14

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      shadow_synced_flag <= 1'b0;
    else if (sync_hold)
      shadow_synced_flag <= 1'b0; // RULE_09
    else if (shadow_copy)
      shadow_synced_flag <= 1'b1; // RULE_08
    else if (sync_clr)
      shadow_synced_flag <= 1'b0; // RULE_10
  end

  // ----------------------------------------------------------------
  // read data and answer
  // ----------------------------------------------------------------
  // shift pending bit is read only; writes never reach it
  logic [31:0] status_word;
  logic [31:0] ctrl_word;

  always_comb
  begin
    status_word                      = 32'h0000_0000;
    status_word[`CSF_WAKEUP_BIT]     = wakeup_expired_flag;
    status_word[`CSF_ALARM2_BIT]     = second_alarm_flag;
    status_word[`CSF_ALARM1_BIT]     = first_alarm_flag;
    status_word[`CSF_INIT_BIT]       = setup_req_q;
    status_word[`CSF_SETUP_ACT_BIT]  = setup_mode_active;
    status_word[`CSF_SYNCED_BIT]     = shadow_synced_flag;
    status_word[`CSF_PROG_BIT]       = calendar_programmed_q;
    status_word[`CSF_SHIFT_PEND_BIT] = shift_pending_flag; // RULE_13
  end

  always_comb
  begin
    ctrl_word                  = 32'h0000_0000;
    ctrl_word[`CSF_BYPASS_BIT] = shadow_bypass_select_q;
  end

  // unmapped offsets and the write-only shift register read as zero
  wire [31:0] rd_word = sel_status ? status_word :
                        sel_ctrl   ? ctrl_word   : 32'h0000_0000;

  // no wait state: pready rises in the first access cycle after setup
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pready <= 1'b0;
    else
      pready <= setup_ph;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pslverr <= 1'b0;
    else
      pslverr <= setup_ph & ~mapped;
  end

  // read data stands only in the answer cycle, zero otherwise
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      prdata <= 32'h0000_0000;
    else
      prdata <= rd_setup ? rd_word : 32'h0000_0000;
  end

endmodule

// ===== csf_regs.svh
// Purpose: register offsets, bit positions and timing counts of the calendar status flags
// Assumes: 32-bit apb data, one aligned word per register
// Notes:   offsets are byte addresses
`ifndef CSF_REGS_SVH
`define CSF_REGS_SVH

`define CSF_STATUS_OFS      12'h000
`define CSF_SHIFT_OFS       12'h004
`define CSF_CTRL_OFS        12'h008

`define CSF_WAKEUP_BIT      10
`define CSF_ALARM2_BIT      9
`define CSF_ALARM1_BIT      8
`define CSF_INIT_BIT        7
`define CSF_SETUP_ACT_BIT   6
`define CSF_SYNCED_BIT      5
`define CSF_PROG_BIT        4
`define CSF_SHIFT_PEND_BIT  3
`define CSF_BYPASS_BIT      0

`define CSF_STATUS_RST      32'h0000_0000
`define CSF_CTRL_RST        32'h0000_0000
`define CSF_SYNC_STAGES     2
`define CSF_SHIFT_CYCLES    4'h4

`endif

// ===== csf_pkg.sv
// Purpose: shared types of the calendar status flags
// Assumes: nothing
// Notes:   setup-mode handshake states
package csf_pkg;
  typedef enum logic [1:0] {
    CSF_RUN,
    CSF_STOPPING,
    CSF_SETUP
  } csf_setup_state_t;
endpackage

// ===== csf_sync.sv
// Purpose: two-stage level synchroniser
// Assumes: single clock, level input
// Notes:   first stage feeds only the second
`timescale 1ns/100ps
module csf_sync
  import csf_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // level
  input  wire logic d,
  output logic      q
);
  logic meta_q;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_q <= 1'b0;
      q      <= 1'b0;
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// ===== csf_flag.sv
// Purpose: one sticky event flag, set by hardware, cleared by a write of zero
// Assumes: set and clear arrive in the same clock
// Notes:   a set in the clear cycle wins so no event is lost
`timescale 1ns/100ps
module csf_flag
  import csf_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // control
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      flag_q
);
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      flag_q <= 1'b0;
    else if (set_i)
      flag_q <= 1'b1;
    else if (clr_i)
      flag_q <= 1'b0;
  end
endmodule

// ===== csf_top_checker.sv
// Purpose: port-level checks of the calendar status flags
// Assumes: events are one-cycle pulses, reads show flags one cycle late
// Notes:   flags are only visible through status reads
`timescale 1ns/100ps
module csf_top_checker (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  // calendar
  input wire logic        wakeup_zero,
  input wire logic        first_alarm_match,
  input wire logic        second_alarm_match,
  input wire logic [7:0]  year_field,
  input wire logic        counter_halt_q,
  input wire logic        shift_start_q,
  input wire logic        shadow_bypass_select_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------
  // decode
  // ----------
  wire acc   = psel && penable && pready;
  wire rd_st = acc && !pwrite && paddr == 12'h000;
  wire wr_st = acc && pwrite && paddr == 12'h000 && pstrb[0];
  wire wr_sh = acc && pwrite && paddr == 12'h004 && pstrb[1];
  sequence s_pulse;
    shift_start_q ##1 !shift_start_q;
  endsequence
  // ----------
  // checks
  // ----------
  a_wakeup_set: assert property ($past(wakeup_zero, 2) && rd_st |-> prdata[10])
    else $error("wakeup flag missed");
  a_second_alarm: assert property ($past(second_alarm_match, 2) && rd_st |-> prdata[9])
    else $error("second alarm flag missed");
  a_first_alarm: assert property ($past(first_alarm_match, 2) && rd_st |-> prdata[8])
    else $error("first alarm flag missed");
  a_year_prog: assert property (rd_st |-> prdata[4] == ($past(year_field, 2) != 8'h00))
    else $error("programmed bit wrong");
  a_halt_on: assert property (wr_st && pwdata[7] |-> ##[1:4] counter_halt_q)
    else $error("halt not raised");
  a_halt_off: assert property (wr_st && !pwdata[7] |-> ##[1:4] !counter_halt_q)
    else $error("halt not dropped");
  a_setup_ack: assert property (rd_st && prdata[6] |-> $past(counter_halt_q, 2))
    else $error("setup active before halt");
  a_bypass_hold: assert property (rd_st && $past(shadow_bypass_select_q)
    && $past(shadow_bypass_select_q, 2) |-> !prdata[5])
    else $error("synced flag set in bypass");
  a_shift_start: assert property (wr_sh |=> s_pulse)
    else $error("shift start pulse wrong");
endmodule

// ===== csf_top_bench.sv
// Purpose: register-level test of the calendar status flags
// Assumes: apb master without wait states of its own
// Notes:   counters_stopped follows the halt request one cycle late
`timescale 1ns/100ps
`include "csf_regs.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module csf_top_bench;
  logic        clk, rst_n, psel, penable, pwrite, stop, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, rdat;
  logic [3:0]  pstrb, evt;
  logic [7:0]  year;
  wire  [31:0] prdata;
  wire         pready, pslverr, halt, shst, byp;
  int          n_mismatch, compares;
  always #2 clk = ~clk;
  always @(posedge clk) stop <= halt;
  csf_top uut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wakeup_zero(evt[3]), .second_alarm_match(evt[2]),
    .first_alarm_match(evt[1]), .shadow_copy(evt[0]), .counters_stopped(stop),
    .year_field(year), .counter_halt_q(halt), .shift_start_q(shst),
    .shadow_bypass_select_q(byp));
  // ----------
  // tasks
  // ----------
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    evt    <= 4'h0;
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    pstrb  <= s;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // the event pulse sits in the cycle just before the read's setup
  task chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input logic [3:0] v);
    @(posedge clk);
    evt <= v;
    xfer(1'h0, a, 32'h0, 4'h0);
    `CHK("read data", e, rdat & m)
  endtask
  task final_report;
    if (n_mismatch == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ----------
  // tests
  // ----------
  initial
  begin
    {clk, rst_n, psel, penable, pwrite, stop, paddr, pwdata, pstrb, evt, year} = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    chk(`CSF_STATUS_OFS, 32'h7f8, 32'h0, 4'h0);
    chk(`CSF_CTRL_OFS, 32'h1, 32'h0, 4'h0);
    xfer(1'h0, 12'h00c, 32'h0, 4'h0);
    `CHK("slave error", 1'h1, err)
    for (int k = 1; k < 4; k++)
    begin
      chk(`CSF_STATUS_OFS, 32'h700, 32'h1 << (7 + k), 4'h1 << k);
      xfer(1'h1, `CSF_STATUS_OFS, 32'h700, 4'h2);
      xfer(1'h1, `CSF_STATUS_OFS, 32'h0, 4'h1);
      chk(`CSF_STATUS_OFS, 32'h700, 32'h1 << (7 + k), 4'h0);
      xfer(1'h1, `CSF_STATUS_OFS, 32'h0, 4'h2);
      chk(`CSF_STATUS_OFS, 32'h700, 32'h0, 4'h0);
    end
    year <= 8'h25;
    chk(`CSF_STATUS_OFS, 32'h10, 32'h10, 4'h0);
    year <= 8'h00;
    chk(`CSF_STATUS_OFS, 32'h20, 32'h20, 4'h1);
    xfer(1'h1, `CSF_STATUS_OFS, 32'h0, 4'h1);
    chk(`CSF_STATUS_OFS, 32'h30, 32'h0, 4'h0);
    xfer(1'h1, `CSF_CTRL_OFS, 32'h1, 4'h3);
    chk(`CSF_CTRL_OFS, 32'h1, 32'h1, 4'h0);
    `CHK("bypass", 1'h1, byp)
    chk(`CSF_STATUS_OFS, 32'h20, 32'h0, 4'h1);
    xfer(1'h1, `CSF_CTRL_OFS, 32'h0, 4'h3);
    xfer(1'h1, `CSF_SHIFT_OFS, 32'h0, 4'h2);
    @(posedge clk);
    `CHK("shift start", 1'h1, shst)
    chk(`CSF_STATUS_OFS, 32'h28, 32'h8, 4'h1);
    repeat (6) @(posedge clk);
    xfer(1'h1, `CSF_STATUS_OFS, 32'h708, 4'hf);
    chk(`CSF_STATUS_OFS, 32'h8, 32'h0, 4'h0);
    xfer(1'h1, `CSF_STATUS_OFS, 32'h780, 4'h3);
    repeat (10) @(posedge clk);
    `CHK("halt", 1'h1, halt)
    chk(`CSF_STATUS_OFS, 32'he0, 32'hc0, 4'h1);
    xfer(1'h1, `CSF_STATUS_OFS, 32'h700, 4'h3);
    repeat (10) @(posedge clk);
    `CHK("halt", 1'h0, halt)
    chk(`CSF_STATUS_OFS, 32'hc0, 32'h0, 4'h0);
    final_report;
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    final_report;
  end
endmodule
bind csf_top csf_top_checker chk_i (.clk(clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .wakeup_zero(wakeup_zero),
  .first_alarm_match(first_alarm_match), .second_alarm_match(second_alarm_match),
  .year_field(year_field), .counter_halt_q(counter_halt_q), .shift_start_q(shift_start_q),
  .shadow_bypass_select_q(shadow_bypass_select_q));
